// File: hw/irq_ctrl.sv
// interrupt source collection, enable gating and two-level priority selection
//
// How it works
// - trigger bit picks edge or level per input
// - edge mode: falling edge sets, service clears
// - level mode: low requests, no service clear
// - timer 0/1 overflows request, not timer0 mode3
// - timer 2 request ORs overflow and pin flags
// - overflow and pin falling edge set timer2 flags
// - each serial request ORs received and transmitted
// - spi request ORs its four flags
// - i2c flag set on four bus events
// - adc flag set when conversion completes
// - counter array request ORs eight flags
// - global enable bit 7 gates every source
// - main enable bits 5..0 select six sources
// - extra enable bits 7,6,5,4,1 select five sources
// - main priority bits 5..0 set six levels
// - extra priority bits set five levels; reset zero
// - flags sampled each cycle, used next cycle
// - each source has fixed vector and poll order
`timescale 1ns/100ps

module irq_ctrl (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// special function register bus
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	// external interrupt pins and their trigger-type bits from the timer control register
	input wire logic ext_irq_pin_zero_i,
	input wire logic ext_irq_pin_one_i,
	input wire logic ext0_edge_select_i,
	input wire logic ext1_edge_select_i,
	// timer events
	input wire logic timer0_overflow_i,
	input wire logic timer0_mode3_i,
	input wire logic timer1_overflow_i,
	input wire logic timer2_overflow_i,
	input wire logic timer2_ext_pin_i,
	// software clear strobes for flags held here
	input wire logic [4:0] flag_clr_i,
	// flags kept by the serial, spi, i2c, adc and counter array peripherals
	input wire logic [1:0] rx_done_flag_i,
	input wire logic [1:0] tx_done_flag_i,
	input wire logic spi_tx_end_flag_i,
	input wire logic spi_rx_overrun_flag_i,
	input wire logic spi_tx_empty_flag_i,
	input wire logic spi_rx_full_flag_i,
	input wire logic i2c_irq_flag_i,
	input wire logic adc_done_flag_i,
	input wire logic [5:0] array_module_match_flags_i,
	input wire logic array_counter0_overflow_flag_i,
	input wire logic array_counter1_overflow_flag_i,
	// core service handshake
	input wire logic svc_ack_i,
	output logic irq_req_o,
	output logic irq_high_o,
	output logic [3:0] irq_source_o,
	output logic [15:0] irq_vector_o,
	// flags held in this block, for software to read
	output logic ext0_pending_flag_o,
	output logic ext1_pending_flag_o,
	output logic timer0_overflow_flag_o,
	output logic timer1_overflow_flag_o,
	output logic timer2_overflow_flag_o,
	output logic timer2_pin_flag_o
);

	// whole state of the block in one record
	typedef struct packed {
		logic [7:0] enable_main;      // global, trace and six source enables
		logic [7:0] enable_extra;     // five more source enables
		logic [7:0] priority_main;    // six priority bits
		logic [7:0] priority_extra;   // five more priority bits
		logic ext0_flag;              // pending flag of external input 0
		logic ext1_flag;              // pending flag of external input 1
		logic t0_flag;                // timer 0 overflow flag
		logic t1_flag;                // timer 1 overflow flag
		logic t2_pin_flag;            // timer 2 pin falling-edge flag
		logic ext0_prev;              // last level of external pin 0
		logic ext1_prev;              // last level of external pin 1
		logic t2x_prev;               // last level of timer 2 pin
		logic t2_flag;                // timer 2 overflow flag
		logic [10:0] sampled;         // source requests taken last cycle
		logic req;                    // a request is presented to the core
		logic high;                   // level of the presented request
		logic [3:0] source;           // index of the presented request
		logic [15:0] vector;          // vector of the presented request
		logic [7:0] rdata;            // read data latch
	} state_s;

	state_s cur;
	state_s next_cur;

	// picks the first set bit of a request vector in polling order
	function automatic logic [4:0] first_set(input logic [10:0] reqs);
		logic [4:0] pick;
		pick = 5'h00;
		for (int i = irq_ctrl_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
			if (reqs[i]) begin
				pick = {1'b1, 4'(i)};
			end
		end
		return pick;
	endfunction : first_set

	// gathers one register bit per source into polling-order vector
	function automatic logic [10:0] per_source(input logic [7:0] main_reg,
			input logic [7:0] extra_reg);
		logic [10:0] v;
		v = 11'h000;
		v[irq_ctrl_pkg::SRC_EXT0] = main_reg[irq_ctrl_pkg::BIT_EXT0];
		v[irq_ctrl_pkg::SRC_TIMER0] = main_reg[irq_ctrl_pkg::BIT_TIMER0];
		v[irq_ctrl_pkg::SRC_EXT1] = main_reg[irq_ctrl_pkg::BIT_EXT1];
		v[irq_ctrl_pkg::SRC_TIMER1] = main_reg[irq_ctrl_pkg::BIT_TIMER1];
		v[irq_ctrl_pkg::SRC_SERIAL0] = main_reg[irq_ctrl_pkg::BIT_SERIAL0];
		v[irq_ctrl_pkg::SRC_TIMER2] = main_reg[irq_ctrl_pkg::BIT_TIMER2];
		v[irq_ctrl_pkg::SRC_SPI] = extra_reg[irq_ctrl_pkg::BIT_SPI];
		v[irq_ctrl_pkg::SRC_I2C] = extra_reg[irq_ctrl_pkg::BIT_I2C];
		v[irq_ctrl_pkg::SRC_ADC] = extra_reg[irq_ctrl_pkg::BIT_ADC];
		v[irq_ctrl_pkg::SRC_ARRAY] = extra_reg[irq_ctrl_pkg::BIT_ARRAY];
		v[irq_ctrl_pkg::SRC_SERIAL1] = extra_reg[irq_ctrl_pkg::BIT_SERIAL1];
		return v;
	endfunction : per_source

	// combinational helpers read by the state update
	logic [10:0] raw_req;       // live request of every source
	logic [10:0] enables;       // per-source enable bits
	logic [10:0] levels;        // per-source priority bits
	logic [10:0] eligible;      // sampled and enabled requests
	logic [4:0] pick_high;      // winner among high-level requests
	logic [4:0] pick_low;       // winner among low-level requests
	logic ext0_fall;            // falling edge seen on external pin 0
	logic ext1_fall;            // falling edge seen on external pin 1
	logic t2x_fall;             // falling edge seen on timer 2 pin
	logic ack_ext0;             // core entered the external 0 routine
	logic ack_ext1;             // core entered the external 1 routine
	logic ack_t0;               // core entered the timer 0 routine
	logic ack_t1;               // core entered the timer 1 routine

	// edge detectors and service decode
	always_comb begin
		ext0_fall = cur.ext0_prev & ~ext_irq_pin_zero_i;
		ext1_fall = cur.ext1_prev & ~ext_irq_pin_one_i;
		t2x_fall = cur.t2x_prev & ~timer2_ext_pin_i;
		// the acknowledge names the request presented in this cycle
		ack_ext0 = svc_ack_i & cur.req & (cur.source == irq_ctrl_pkg::SRC_EXT0);
		ack_ext1 = svc_ack_i & cur.req & (cur.source == irq_ctrl_pkg::SRC_EXT1);
		ack_t0 = svc_ack_i & cur.req & (cur.source == irq_ctrl_pkg::SRC_TIMER0);
		ack_t1 = svc_ack_i & cur.req & (cur.source == irq_ctrl_pkg::SRC_TIMER1);
	end

	// live request of each source
	always_comb begin
		raw_req = 11'h000;
		raw_req[irq_ctrl_pkg::SRC_EXT0] = cur.ext0_flag;
		raw_req[irq_ctrl_pkg::SRC_EXT1] = cur.ext1_flag;
		raw_req[irq_ctrl_pkg::SRC_TIMER0] = cur.t0_flag;
		raw_req[irq_ctrl_pkg::SRC_TIMER1] = cur.t1_flag;
		raw_req[irq_ctrl_pkg::SRC_TIMER2] = cur.t2_flag | cur.t2_pin_flag;
		raw_req[irq_ctrl_pkg::SRC_SERIAL0] = rx_done_flag_i[0] | tx_done_flag_i[0];
		raw_req[irq_ctrl_pkg::SRC_SERIAL1] = rx_done_flag_i[1] | tx_done_flag_i[1];
		raw_req[irq_ctrl_pkg::SRC_SPI] = spi_tx_end_flag_i | spi_rx_overrun_flag_i |
			spi_tx_empty_flag_i | spi_rx_full_flag_i;
		raw_req[irq_ctrl_pkg::SRC_I2C] = i2c_irq_flag_i;
		raw_req[irq_ctrl_pkg::SRC_ADC] = adc_done_flag_i;
		raw_req[irq_ctrl_pkg::SRC_ARRAY] = (|array_module_match_flags_i) |
			array_counter0_overflow_flag_i | array_counter1_overflow_flag_i;
	end

	// gating and two-level selection on last cycle's sample
	always_comb begin
		enables = per_source(cur.enable_main, cur.enable_extra);
		levels = per_source(cur.priority_main, cur.priority_extra);
		eligible = cur.enable_main[irq_ctrl_pkg::BIT_GLOBAL_ENABLE] ?
			(cur.sampled & enables) : 11'h000;
		pick_high = first_set(eligible & levels);
		pick_low = first_set(eligible & ~levels);
	end

	// next state
	always_comb begin
		next_cur = cur;
		next_cur.ext0_prev = ext_irq_pin_zero_i;
		next_cur.ext1_prev = ext_irq_pin_one_i;
		next_cur.t2x_prev = timer2_ext_pin_i;

		if (ext0_edge_select_i) begin
			// edge set beats service and software clear
			if (ext0_fall) begin
				next_cur.ext0_flag = 1'b1;
			end else if (ack_ext0 | flag_clr_i[irq_ctrl_pkg::CLR_EXT0]) begin
				next_cur.ext0_flag = 1'b0;
			end
		end else begin
			// level follows the pin, service does not clear
			next_cur.ext0_flag = ~ext_irq_pin_zero_i;
		end

		if (ext1_edge_select_i) begin
			if (ext1_fall) begin
				next_cur.ext1_flag = 1'b1;
			end else if (ack_ext1 | flag_clr_i[irq_ctrl_pkg::CLR_EXT1]) begin
				next_cur.ext1_flag = 1'b0;
			end
		end else begin
			next_cur.ext1_flag = ~ext_irq_pin_one_i;
		end

		// timer 0 flag; counter overflow ignored in mode 3
		if (timer0_overflow_i & ~timer0_mode3_i) begin
			next_cur.t0_flag = 1'b1;
		end else if (ack_t0 | flag_clr_i[irq_ctrl_pkg::CLR_TIMER0]) begin
			next_cur.t0_flag = 1'b0;
		end

		// timer 1 flag, cleared on service
		if (timer1_overflow_i) begin
			next_cur.t1_flag = 1'b1;
		end else if (ack_t1 | flag_clr_i[irq_ctrl_pkg::CLR_TIMER1]) begin
			next_cur.t1_flag = 1'b0;
		end

		// timer 2 flags; software alone clears them
		if (t2x_fall) begin
			next_cur.t2_pin_flag = 1'b1;
		end else if (flag_clr_i[irq_ctrl_pkg::CLR_TIMER2_PIN]) begin
			next_cur.t2_pin_flag = 1'b0;
		end
		// overflow flag has no strobe of its own, so it shares the timer 2 clear;
		// software that wants one cause only must re-read both flags afterwards
		if (timer2_overflow_i) begin
			next_cur.t2_flag = 1'b1;
		end else if (flag_clr_i[irq_ctrl_pkg::CLR_TIMER2_PIN]) begin
			next_cur.t2_flag = 1'b0;
		end

		next_cur.sampled = raw_req;

		// present winner with its fixed vector
		if (pick_high[4]) begin
			next_cur.req = 1'b1;
			next_cur.high = 1'b1;
			next_cur.source = pick_high[3:0];
			next_cur.vector = irq_ctrl_pkg::VECTOR_TABLE[pick_high[3:0]];
		end else if (pick_low[4]) begin
			next_cur.req = 1'b1;
			next_cur.high = 1'b0;
			next_cur.source = pick_low[3:0];
			next_cur.vector = irq_ctrl_pkg::VECTOR_TABLE[pick_low[3:0]];
		end else begin
			// nothing eligible: drop the request, keep the rest quiet
			next_cur.req = 1'b0;
			next_cur.high = 1'b0;
			next_cur.source = 4'h0;
			next_cur.vector = 16'h0000;
		end

		// register writes; reserved bits are masked so they stay zero
		if (sfr_wr_i) begin
			case (sfr_addr_i)
				// full byte stored, trace bit held as written
				irq_ctrl_pkg::ADDR_ENABLE_MAIN: begin
					next_cur.enable_main = sfr_wdata_i & irq_ctrl_pkg::MASK_ENABLE_MAIN;
				end
				irq_ctrl_pkg::ADDR_ENABLE_EXTRA: begin
					next_cur.enable_extra = sfr_wdata_i & irq_ctrl_pkg::MASK_ENABLE_EXTRA;
				end
				irq_ctrl_pkg::ADDR_PRIORITY_MAIN: begin
					next_cur.priority_main = sfr_wdata_i & irq_ctrl_pkg::MASK_PRIORITY_MAIN;
				end
				irq_ctrl_pkg::ADDR_PRIORITY_EXTRA: begin
					next_cur.priority_extra = sfr_wdata_i & irq_ctrl_pkg::MASK_PRIORITY_EXTRA;
				end
				// other addresses belong to other blocks
				default: begin
					next_cur.enable_main = cur.enable_main;
				end
			endcase
		end

		// read data latched on the strobe, zero for foreign addresses
		if (sfr_rd_i) begin
			case (sfr_addr_i)
				irq_ctrl_pkg::ADDR_ENABLE_MAIN: begin
					next_cur.rdata = cur.enable_main;
				end
				irq_ctrl_pkg::ADDR_ENABLE_EXTRA: begin
					next_cur.rdata = cur.enable_extra;
				end
				irq_ctrl_pkg::ADDR_PRIORITY_MAIN: begin
					next_cur.rdata = cur.priority_main;
				end
				irq_ctrl_pkg::ADDR_PRIORITY_EXTRA: begin
					next_cur.rdata = cur.priority_extra;
				end
				default: begin
					next_cur.rdata = 8'h00;
				end
			endcase
		end
	end

	// state register; pin history resets high, so a pin held low at reset release is taken as a falling edge
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cur.enable_main <= irq_ctrl_pkg::RESET_ENABLE_MAIN;
			cur.enable_extra <= irq_ctrl_pkg::RESET_ENABLE_EXTRA;
			cur.priority_main <= irq_ctrl_pkg::RESET_PRIORITY_MAIN;
			cur.priority_extra <= irq_ctrl_pkg::RESET_PRIORITY_EXTRA;
			cur.ext0_flag <= 1'b0;
			cur.ext1_flag <= 1'b0;
			cur.t0_flag <= 1'b0;
			cur.t1_flag <= 1'b0;
			cur.t2_pin_flag <= 1'b0;
			cur.ext0_prev <= 1'b1;
			cur.ext1_prev <= 1'b1;
			cur.t2x_prev <= 1'b1;
			cur.t2_flag <= 1'b0;
			cur.sampled <= 11'h000;
			cur.req <= 1'b0;
			cur.high <= 1'b0;
			cur.source <= 4'h0;
			cur.vector <= 16'h0000;
			cur.rdata <= 8'h00;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from the state record
	assign sfr_rdata_o = cur.rdata;
	assign irq_req_o = cur.req;
	assign irq_high_o = cur.high;
	assign irq_source_o = cur.source;
	assign irq_vector_o = cur.vector;
	assign ext0_pending_flag_o = cur.ext0_flag;
	assign ext1_pending_flag_o = cur.ext1_flag;
	assign timer0_overflow_flag_o = cur.t0_flag;
	assign timer1_overflow_flag_o = cur.t1_flag;
	assign timer2_overflow_flag_o = cur.t2_flag;
	assign timer2_pin_flag_o = cur.t2_pin_flag;

endmodule : irq_ctrl

// File: hw/irq_ctrl_pkg.sv
// shared constants for the interrupt source, enable and priority block
package irq_ctrl_pkg;
	// register addresses on the special function register bus
	localparam logic [7:0] ADDR_ENABLE_EXTRA = 8'hA7;
	localparam logic [7:0] ADDR_ENABLE_MAIN = 8'hA8;
	localparam logic [7:0] ADDR_PRIORITY_EXTRA = 8'hB7;
	localparam logic [7:0] ADDR_PRIORITY_MAIN = 8'hB8;
	// reset values, all four registers clear
	localparam logic [7:0] RESET_ENABLE_EXTRA = 8'h00;
	localparam logic [7:0] RESET_ENABLE_MAIN = 8'h00;
	localparam logic [7:0] RESET_PRIORITY_EXTRA = 8'h00;
	localparam logic [7:0] RESET_PRIORITY_MAIN = 8'h00;
	// writable bit masks; reserved bits stay zero and read zero
	localparam logic [7:0] MASK_ENABLE_MAIN = 8'hFF;
	localparam logic [7:0] MASK_ENABLE_EXTRA = 8'hF2;
	localparam logic [7:0] MASK_PRIORITY_MAIN = 8'h3F;
	localparam logic [7:0] MASK_PRIORITY_EXTRA = 8'hF2;
	// bit positions in the main enable and main priority registers
	localparam int BIT_GLOBAL_ENABLE = 7;
	localparam int BIT_TRACE = 6;
	localparam int BIT_TIMER2 = 5;
	localparam int BIT_SERIAL0 = 4;
	localparam int BIT_TIMER1 = 3;
	localparam int BIT_EXT1 = 2;
	localparam int BIT_TIMER0 = 1;
	localparam int BIT_EXT0 = 0;
	// bit positions in the extra enable and extra priority registers
	localparam int BIT_ADC = 7;
	localparam int BIT_SPI = 6;
	localparam int BIT_ARRAY = 5;
	localparam int BIT_SERIAL1 = 4;
	localparam int BIT_I2C = 1;
	// source indices, in polling order (index 0 polled first)
	localparam int NUM_SOURCES = 11;
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_TIMER0 = 4'h1;
	localparam logic [3:0] SRC_EXT1 = 4'h2;
	localparam logic [3:0] SRC_TIMER1 = 4'h3;
	localparam logic [3:0] SRC_SERIAL0 = 4'h4;
	localparam logic [3:0] SRC_TIMER2 = 4'h5;
	localparam logic [3:0] SRC_SPI = 4'h6;
	localparam logic [3:0] SRC_I2C = 4'h7;
	localparam logic [3:0] SRC_ADC = 4'h8;
	localparam logic [3:0] SRC_ARRAY = 4'h9;
	localparam logic [3:0] SRC_SERIAL1 = 4'hA;
	// vector address of each source, element n belongs to source index n
	localparam logic [10:0][15:0] VECTOR_TABLE = {
		16'h004B, 16'h005B, 16'h003B, 16'h0043, 16'h0053, 16'h002B,
		16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};
	// flag clear strobe positions for the flags held in this block
	localparam int CLR_EXT0 = 0;
	localparam int CLR_EXT1 = 1;
	localparam int CLR_TIMER0 = 2;
	localparam int CLR_TIMER1 = 3;
	localparam int CLR_TIMER2_PIN = 4;
endpackage : irq_ctrl_pkg

// File: testbench/irq_ctrl_monitor.sv
// port-level checks for the interrupt block
`timescale 1ns/100ps
module irq_ctrl_monitor (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// register bus
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_rdata_o,
	// pins and timer controls
	input wire logic ext_irq_pin_zero_i,
	input wire logic ext_irq_pin_one_i,
	input wire logic ext0_edge_select_i,
	input wire logic ext1_edge_select_i,
	input wire logic timer0_mode3_i,
	input wire logic timer2_overflow_i,
	// service side
	input wire logic svc_ack_i,
	input wire logic irq_req_o,
	input wire logic [3:0] irq_source_o,
	input wire logic [15:0] irq_vector_o,
	input wire logic ext0_pending_flag_o,
	input wire logic ext1_pending_flag_o,
	input wire logic timer0_overflow_flag_o,
	input wire logic timer2_overflow_flag_o
);
	// single domain, so one clock and one reset serve all checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	// high for any address outside the four registers
	logic unmapped;
	assign unmapped = !(sfr_addr_i inside {irq_ctrl_pkg::ADDR_ENABLE_EXTRA,
		irq_ctrl_pkg::ADDR_ENABLE_MAIN, irq_ctrl_pkg::ADDR_PRIORITY_EXTRA,
		irq_ctrl_pkg::ADDR_PRIORITY_MAIN});
	a_edge_sets: assert property (
		ext0_edge_select_i && $fell(ext_irq_pin_zero_i) |=> ext0_pending_flag_o)
		else $error("ext0 flag missed a falling edge");
	a_level_mirror: assert property (
		!ext1_edge_select_i |=> ext1_pending_flag_o == !$past(ext_irq_pin_one_i))
		else $error("ext1 flag does not follow the low level");
	a_ack_clears: assert property (svc_ack_i && irq_req_o && ext0_edge_select_i &&
		irq_source_o == irq_ctrl_pkg::SRC_EXT0 && !$fell(ext_irq_pin_zero_i)
		|=> !ext0_pending_flag_o) else $error("ext0 flag survived service entry");
	a_mode3_mute: assert property (
		timer0_mode3_i && !timer0_overflow_flag_o |=> !timer0_overflow_flag_o)
		else $error("timer0 flag set in mode 3");
	a_t2_overflow: assert property (
		timer2_overflow_i |=> timer2_overflow_flag_o)
		else $error("timer2 overflow flag not set");
	a_global_off: assert property (sfr_wr_i && !sfr_wdata_i[7] &&
		sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_MAIN |-> ##2 !irq_req_o)
		else $error("request kept with global enable off");
	a_vector_map: assert property (
		irq_req_o |-> irq_vector_o == irq_ctrl_pkg::VECTOR_TABLE[irq_source_o])
		else $error("vector does not match source");
	a_unmapped_read: assert property (
		sfr_rd_i && unmapped |=> sfr_rdata_o == 8'h00)
		else $error("unmapped read not zero");
endmodule : irq_ctrl_monitor

// File: testbench/irq_core_model.sv
// core side model: register bus master and service acknowledge
`timescale 1ns/100ps
module irq_core_model (
	// clock
	input wire logic ref_clk_i,
	// register bus toward the block
	output logic [7:0] sfr_addr_o,
	output logic [7:0] sfr_wdata_o,
	output logic sfr_wr_o,
	output logic sfr_rd_o,
	input wire logic [7:0] sfr_rdata_i,
	// service handshake
	output logic svc_ack_o,
	input wire logic irq_req_i,
	input wire logic [3:0] irq_source_i
);
	// bus idle from time zero
	initial begin
		sfr_addr_o = 8'h00;
		sfr_wdata_o = 8'h00;
		sfr_wr_o = 1'b0;
		sfr_rd_o = 1'b0;
		svc_ack_o = 1'b0;
	end
	// one-edge write; released lines show the inverse, never a stale copy
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		sfr_addr_o = a;
		sfr_wdata_o = d;
		sfr_wr_o = 1'b1;
		@(negedge ref_clk_i);
		sfr_wr_o = 1'b0;
		sfr_addr_o = ~a;
		sfr_wdata_o = ~d;
	endtask : wr
	// one-edge read; data is registered at the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk_i);
		sfr_addr_o = a;
		sfr_rd_o = 1'b1;
		@(negedge ref_clk_i);
		sfr_rd_o = 1'b0;
		sfr_addr_o = ~a;
		d = sfr_rdata_i;
	endtask : rd
	task automatic wr_main(input logic [7:0] d);
		logic [7:0] old;
		rd(irq_ctrl_pkg::ADDR_ENABLE_MAIN, old);
		wr(irq_ctrl_pkg::ADDR_ENABLE_MAIN, {d[7], old[6], d[5:0]});
	endtask : wr_main
	task automatic wr_extra(input logic [7:0] d);
		wr(irq_ctrl_pkg::ADDR_ENABLE_EXTRA, d & 8'hF2);
	endtask : wr_extra
	// acknowledge after a chosen wait, only while a request stands
	task automatic service(input int wait_n, output logic [3:0] src);
		repeat (wait_n) @(negedge ref_clk_i);
		src = irq_source_i;
		svc_ack_o = irq_req_i;
		@(negedge ref_clk_i);
		svc_ack_o = 1'b0;
	endtask : service
endmodule : irq_core_model

// File: testbench/irq_ctrl_tb.sv
// self-checking bench for the interrupt source, enable and priority block
`timescale 1ns/100ps
module irq_ctrl_tb;
	// stimulus toward the block
	logic clk, rstn, p0, p1, es0, es1, t0o, t0m3, t1o, t2o, t2p;
	logic [4:0] clr;
	logic [17:0] lv; // peripheral flag levels, one bit per cause
	// bus and outputs
	logic [7:0] addr, wdata, rdata;
	logic wr, rd, ack, req, high, f_e0, f_e1, f_t0, f_t1, f_t2, f_t2p;
	logic [3:0] src;
	logic [15:0] vec;
	int num_errors, cmp_count, cycles;
	logic [7:0] addrs [5] = '{8'hA7, 8'hA8, 8'hB7, 8'hB8, 8'hC3};
	logic [7:0] masks [5] = '{8'hF2, 8'hFF, 8'hF2, 8'h3F, 8'h00};
	irq_ctrl dut_u (.ref_clk_i(clk), .rstn_i(rstn), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .ext_irq_pin_zero_i(p0),
		.ext_irq_pin_one_i(p1), .ext0_edge_select_i(es0), .ext1_edge_select_i(es1),
		.timer0_overflow_i(t0o), .timer0_mode3_i(t0m3), .timer1_overflow_i(t1o),
		.timer2_overflow_i(t2o), .timer2_ext_pin_i(t2p), .flag_clr_i(clr),
		.rx_done_flag_i({lv[2], lv[0]}), .tx_done_flag_i({lv[3], lv[1]}),
		.spi_tx_end_flag_i(lv[4]), .spi_rx_overrun_flag_i(lv[5]), .spi_tx_empty_flag_i(lv[6]),
		.spi_rx_full_flag_i(lv[7]), .i2c_irq_flag_i(lv[8]), .adc_done_flag_i(lv[9]),
		.array_module_match_flags_i(lv[15:10]), .array_counter0_overflow_flag_i(lv[16]),
		.array_counter1_overflow_flag_i(lv[17]), .svc_ack_i(ack), .irq_req_o(req),
		.irq_high_o(high), .irq_source_o(src), .irq_vector_o(vec), .ext0_pending_flag_o(f_e0),
		.ext1_pending_flag_o(f_e1), .timer0_overflow_flag_o(f_t0),
		.timer1_overflow_flag_o(f_t1), .timer2_overflow_flag_o(f_t2), .timer2_pin_flag_o(f_t2p));
	irq_core_model core_u (.ref_clk_i(clk), .sfr_addr_o(addr), .sfr_wdata_o(wdata),
		.sfr_wr_o(wr), .sfr_rd_o(rd), .sfr_rdata_i(rdata), .svc_ack_o(ack),
		.irq_req_i(req), .irq_source_i(src));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// hang guard, far above the several hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic chk_bit(input string n, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask : chk_bit
	task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk_val
	// bounded wait for the request line to reach a level
	task automatic wait_req(input logic v);
		for (int n = 0; n < 8 && req !== v; n++) begin
			@(negedge clk);
		end
		chk_bit("irq_req", v, req);
	endtask : wait_req
	// one-cycle event pulse on a timer input: 0, 1 or 2
	task automatic pulse(input int t);
		t0o = (t == 0);
		t1o = (t == 1);
		t2o = (t == 2);
		@(negedge clk);
		t0o = 1'b0;
		t1o = 1'b0;
		t2o = 1'b0;
	endtask : pulse
	// {source, vector, main enable, extra enable} for each peripheral cause
	function automatic logic [35:0] expect_of(input int k);
		if (k < 2) return {4'h4, 16'h0023, 8'h90, 8'h00};
		if (k < 4) return {4'hA, 16'h004B, 8'h80, 8'h10};
		if (k < 8) return {4'h6, 16'h0053, 8'h80, 8'h40};
		if (k == 8) return {4'h7, 16'h0043, 8'h80, 8'h02};
		if (k == 9) return {4'h8, 16'h003B, 8'h80, 8'h80};
		return {4'h9, 16'h005B, 8'h80, 8'h20};
	endfunction : expect_of
	task automatic t_registers();
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			core_u.rd(addrs[i], d);
			chk_val("reset value", 16'h0000, {8'h00, d});
			core_u.wr(addrs[i], 8'hFF);
			core_u.rd(addrs[i], d);
			chk_val("readback", {8'h00, masks[i]}, {8'h00, d});
			core_u.wr(addrs[i], 8'h00);
		end
	endtask : t_registers
	task automatic t_ext();
		logic [3:0] s;
		core_u.wr_main(8'h81);
		p0 = 1'b0;
		@(negedge clk);
		chk_bit("ext0 flag", 1'b1, f_e0);
		wait_req(1'b1);
		chk_val("ext0 vector", 16'h0003, vec);
		core_u.service(0, s);
		chk_bit("ext0 cleared", 1'b0, f_e0);
		wait_req(1'b0);
		chk_bit("ext0 no refire", 1'b0, f_e0);
		p0 = 1'b1;
		core_u.wr_main(8'h84);
		p1 = 1'b0;
		wait_req(1'b1);
		core_u.service(5, s);
		chk_val("ext1 source", 16'h0002, {12'h000, s});
		chk_bit("ext1 kept", 1'b1, f_e1);
		core_u.wr_main(8'h04);
		wait_req(1'b0);
		core_u.wr_main(8'h84);
		wait_req(1'b1);
		p1 = 1'b1;
		wait_req(1'b0);
		// ext1 in edge mode: service entry clears it
		es1 = 1'b1;
		p1 = 1'b0;
		wait_req(1'b1);
		core_u.service(0, s);
		chk_bit("ext1 edge cleared", 1'b0, f_e1);
		wait_req(1'b0);
		p1 = 1'b1;
		// ext0 in level mode: service entry leaves it set
		core_u.wr_main(8'h81);
		es0 = 1'b0;
		p0 = 1'b0;
		wait_req(1'b1);
		core_u.service(0, s);
		chk_val("ext0 level source", 16'h0000, {12'h000, s});
		chk_bit("ext0 level kept", 1'b1, f_e0);
		p0 = 1'b1;
		wait_req(1'b0);
		es0 = 1'b1;
	endtask : t_ext
	task automatic t_timers();
		logic [3:0] s;
		core_u.wr_main(8'hAA);
		t0m3 = 1'b1;
		pulse(0);
		@(negedge clk);
		chk_bit("t0 muted", 1'b0, f_t0);
		t0m3 = 1'b0;
		pulse(0);
		wait_req(1'b1);
		chk_val("t0 vector", 16'h000B, vec);
		core_u.service(0, s);
		chk_bit("t0 cleared", 1'b0, f_t0);
		wait_req(1'b0);
		pulse(1);
		wait_req(1'b1);
		chk_val("t1 vector", 16'h001B, vec);
		core_u.service(3, s);
		chk_bit("t1 cleared", 1'b0, f_t1);
		pulse(2);
		chk_bit("t2 flag", 1'b1, f_t2);
		t2p = 1'b0;
		@(negedge clk);
		chk_bit("t2 pin flag", 1'b1, f_t2p);
		wait_req(1'b1);
		chk_val("t2 vector", 16'h002B, vec);
		clr = 5'h10;
		@(negedge clk);
		clr = 5'h00;
		t2p = 1'b1;
		wait_req(1'b0);
	endtask : t_timers
	task automatic t_periph();
		logic [35:0] e;
		for (int k = 0; k < 18; k++) begin
			e = expect_of(k);
			core_u.wr_main(e[15:8] & 8'h7F);
			core_u.wr_extra(e[7:0]);
			lv = 18'h00001 << k;
			repeat (4) @(negedge clk);
			chk_bit("gated off", 1'b0, req);
			core_u.wr_main(e[15:8]);
			wait_req(1'b1);
			chk_val("source", {12'h000, e[35:32]}, {12'h000, src});
			chk_val("vector", e[31:16], vec);
			lv = 18'h00000;
			wait_req(1'b0);
		end
	endtask : t_periph
	task automatic t_priority();
		core_u.wr_main(8'h90);
		core_u.wr_extra(8'h80);
		lv = 18'h00201;
		wait_req(1'b1);
		chk_val("low pair", 16'h0004, {12'h000, src});
		core_u.wr(irq_ctrl_pkg::ADDR_PRIORITY_EXTRA, 8'h80);
		repeat (3) @(negedge clk);
		chk_val("adc high", 16'h0008, {12'h000, src});
		chk_bit("level", 1'b1, high);
		core_u.wr(irq_ctrl_pkg::ADDR_PRIORITY_MAIN, 8'h10);
		repeat (3) @(negedge clk);
		chk_val("both high", 16'h0004, {12'h000, src});
		lv = 18'h00000;
		wait_req(1'b0);
	endtask : t_priority
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up
	// reset, then the scenarios in turn
	initial begin
		rstn = 1'b0;
		p0 = 1'b1;
		p1 = 1'b1;
		es0 = 1'b1;
		es1 = 1'b0;
		t0o = 1'b0;
		t0m3 = 1'b0;
		t1o = 1'b0;
		t2o = 1'b0;
		t2p = 1'b1;
		clr = 5'h00;
		lv = 18'h00000;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		t_registers();
		t_ext();
		t_timers();
		t_periph();
		t_priority();
		wrap_up();
	end
endmodule : irq_ctrl_tb
bind irq_ctrl irq_ctrl_monitor mon_u (.ref_clk_i, .rstn_i, .sfr_addr_i, .sfr_wdata_i,
	.sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .ext_irq_pin_zero_i, .ext_irq_pin_one_i,
	.ext0_edge_select_i, .ext1_edge_select_i, .timer0_mode3_i, .timer2_overflow_i,
	.svc_ack_i, .irq_req_o, .irq_source_o, .irq_vector_o, .ext0_pending_flag_o,
	.ext1_pending_flag_o, .timer0_overflow_flag_o, .timer2_overflow_flag_o);
